// ---- src/b4sp_ctl_end.sv ----
// controller end of the burst-of-four link: clock divider, sequencer, capture
`timescale 1ns/100ps
module b4sp_ctl_end (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    b4sp_link_if.ctl link,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [b4sp_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic [b4sp_pkg::BEAT_N*b4sp_pkg::DATA_W-1:0] req_wdata_i,
    input wire logic [b4sp_pkg::BEAT_N*b4sp_pkg::LANE_N-1:0] req_mask_n_i,
    input wire logic dll_reset_i,
    output logic req_ready_o,
    output logic link_ready_o,
    output logic [b4sp_pkg::BEAT_N*b4sp_pkg::DATA_W-1:0] rd_data_o,
    output logic rd_valid_o
);
    import b4sp_pkg::*;

    typedef enum logic [4:0] {
        ST_DOFF = 5'b00001, // dll disable held low
        ST_LOCK = 5'b00010, // waiting for relock
        ST_IDLE = 5'b00100, // ready for a request
        ST_CMD = 5'b01000, // command on next fall
        ST_BEAT = 5'b10000 // beats on following falls
    } b4sp_ctl_state_t;

    // ****************************************
    // link clock divider and sequencer
    // ****************************************
    b4sp_ctl_state_t st_q, st_d; // sequencer state
    logic [2:0] kdiv_q, kdiv_d; // phase counter
    logic k_q, k_d; // link clock out
    logic k_fall; // link clock falls this edge
    logic [11:0] cnt_q, cnt_d; // disable and lock counter
    logic doff_n_q, doff_n_d; // dll disable out
    logic rsel_n_q, rsel_n_d; // read select out
    logic wsel_n_q, wsel_n_d; // write select out
    logic [ADDR_W-1:0] addr_q, addr_d; // address out
    logic [DATA_W-1:0] din_q, din_d; // write beat out
    logic [LANE_N-1:0] mask_q, mask_d; // lane masks out
    logic wr_q, wr_d; // request is a write
    logic [ADDR_W-1:0] raddr_q, raddr_d; // request address
    logic [BEAT_N*DATA_W-1:0] wdata_q, wdata_d; // request beats
    logic [BEAT_N*LANE_N-1:0] wmask_q, wmask_d; // request masks
    logic [IDX_W-1:0] beat_q, beat_d; // beat counter
    logic ready_q, ready_d; // request port ready
    logic lready_q, lready_d; // link locked and usable

    assign k_fall = (kdiv_q == K_HALF_LAST) & k_q;

    // select, address and data outputs change on link clock falls so the sram samples settled pins
    always_comb begin
        kdiv_d = (kdiv_q == K_HALF_LAST) ? 3'h0 : kdiv_q + 3'h1;
        k_d = (kdiv_q == K_HALF_LAST) ? ~k_q : k_q;
        st_d = st_q;
        cnt_d = cnt_q;
        doff_n_d = doff_n_q;
        rsel_n_d = rsel_n_q;
        wsel_n_d = wsel_n_q;
        addr_d = addr_q;
        din_d = din_q;
        mask_d = mask_q;
        wr_d = wr_q;
        raddr_d = raddr_q;
        wdata_d = wdata_q;
        wmask_d = wmask_q;
        beat_d = beat_q;
        ready_d = ready_q;
        lready_d = lready_q;
        case (st_q)
            ST_DOFF: begin
                // hold disable low, then release
                cnt_d = cnt_q + 12'h001;
                if (cnt_q == DOFF_LAST) begin
                    doff_n_d = 1'b1;
                    cnt_d = 12'h000;
                    st_d = ST_LOCK;
                end
            end
            ST_LOCK: begin
                // give the dll its full relock interval
                if (k_fall) begin
                    cnt_d = cnt_q + 12'h001;
                    if (cnt_q == LOCK_LAST) begin
                        st_d = ST_IDLE;
                        ready_d = 1'b1;
                        lready_d = 1'b1;
                    end
                end
            end
            ST_IDLE: begin
                // take a request
                if (req_valid_i) begin
                    wr_d = req_write_i;
                    raddr_d = req_addr_i;
                    wdata_d = req_wdata_i;
                    wmask_d = req_mask_n_i;
                    ready_d = 1'b0;
                    st_d = ST_CMD;
                end
            end
            ST_CMD: begin
                // one select low for one link cycle
                if (k_fall) begin
                    rsel_n_d = wr_q;
                    wsel_n_d = ~wr_q;
                    addr_d = raddr_q;
                    beat_d = 2'h0;
                    st_d = ST_BEAT;
                end
            end
            ST_BEAT: begin
                // four beats, each write beat with its own mask set
                if (k_fall) begin
                    rsel_n_d = 1'b1;
                    wsel_n_d = 1'b1;
                    if (wr_q) begin
                        din_d = wdata_q[beat_q*DATA_W +: DATA_W];
                        mask_d = wmask_q[beat_q*LANE_N +: LANE_N];
                    end
                    beat_d = beat_q + 2'h1;
                    if (beat_q == 2'h3) begin
                        st_d = ST_IDLE;
                        ready_d = 1'b1;
                    end
                end
            end
            default: begin
                st_d = ST_DOFF;
            end
        endcase
        // a dll reset request aborts the sequencer and restarts the dll-disable step
        if (dll_reset_i) begin
            st_d = ST_DOFF;
            cnt_d = 12'h000;
            doff_n_d = 1'b0;
            rsel_n_d = 1'b1;
            wsel_n_d = 1'b1;
            ready_d = 1'b0;
            lready_d = 1'b0;
        end
    end

    // sequencer registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= ST_DOFF;
            kdiv_q <= 3'h0;
            k_q <= 1'b0;
            cnt_q <= 12'h000;
            doff_n_q <= 1'b0;
            rsel_n_q <= 1'b1;
            wsel_n_q <= 1'b1;
            addr_q <= '0;
            din_q <= DATA_RST;
            mask_q <= MASK_RST;
            wr_q <= 1'b0;
            raddr_q <= '0;
            wdata_q <= '0;
            wmask_q <= '1;
            beat_q <= 2'h0;
            ready_q <= 1'b0;
            lready_q <= 1'b0;
        end else begin
            st_q <= st_d;
            kdiv_q <= kdiv_d;
            k_q <= k_d;
            cnt_q <= cnt_d;
            doff_n_q <= doff_n_d;
            rsel_n_q <= rsel_n_d;
            wsel_n_q <= wsel_n_d;
            addr_q <= addr_d;
            din_q <= din_d;
            mask_q <= mask_d;
            wr_q <= wr_d;
            raddr_q <= raddr_d;
            wdata_q <= wdata_d;
            wmask_q <= wmask_d;
            beat_q <= beat_d;
            ready_q <= ready_d;
            lready_q <= lready_d;
        end
    end

    // ****************************************
    // read capture on echo strobe edges
    // ****************************************
    logic [DATA_W+1:0] rx_s1_q, rx_s2_q; // synced valid, echo, data
    logic echo_s3_q; // previous echo level
    logic cap_q, cap_d; // capture data next cycle
    logic [IDX_W-1:0] ridx_q, ridx_d; // received beat count
    logic [BEAT_N*DATA_W-1:0] rdat_q, rdat_d; // assembled burst
    logic rvld_q, rvld_d; // burst complete pulse

    // two flops on the returning pins
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_s1_q <= '0;
            rx_s2_q <= '0;
            echo_s3_q <= 1'b0;
        end else begin
            rx_s1_q <= {link.read_valid_flag, link.echo_strobe_pos, link.q_bus};
            rx_s2_q <= rx_s1_q;
            echo_s3_q <= rx_s2_q[DATA_W];
        end
    end

    // sample one cycle after the echo edge so the data has settled
    always_comb begin
        cap_d = (rx_s2_q[DATA_W] ^ echo_s3_q) & rx_s2_q[DATA_W+1];
        ridx_d = ridx_q;
        rdat_d = rdat_q;
        rvld_d = 1'b0;
        if (cap_q) begin
            rdat_d[ridx_q*DATA_W +: DATA_W] = rx_s2_q[DATA_W-1:0];
            ridx_d = ridx_q + 2'h1;
            rvld_d = (ridx_q == 2'h3);
        end else if (!rx_s2_q[DATA_W+1]) begin
            ridx_d = 2'h0;
        end
    end

    // capture registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cap_q <= 1'b0;
            ridx_q <= 2'h0;
            rdat_q <= '0;
            rvld_q <= 1'b0;
        end else begin
            cap_q <= cap_d;
            ridx_q <= ridx_d;
            rdat_q <= rdat_d;
            rvld_q <= rvld_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign link.k = k_q;
    assign link.dll_off_n = doff_n_q;
    assign link.rd_sel_n = rsel_n_q;
    assign link.wr_sel_n = wsel_n_q;
    assign link.addr = addr_q;
    assign link.din = din_q;
    assign link.lane_write_mask_n = mask_q;
    assign req_ready_o = ready_q;
    assign link_ready_o = lready_q;
    assign rd_data_o = rdat_q;
    assign rd_valid_o = rvld_q;
endmodule : b4sp_ctl_end

// ---- src/b4sp_pkg.sv ----
// shared constants for the burst-of-four sram link pair
package b4sp_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam int ADDR_W = 4; // burst address width
    localparam int LANE_N = 2; // byte lanes per beat (narrow organisation)
    localparam int LANE_W = 9; // bits per lane
    localparam int DATA_W = LANE_N * LANE_W; // beat width
    localparam int BEAT_N = 4; // beats per burst
    localparam int WORD_N = BEAT_N << ADDR_W; // words in the array
    localparam int IDX_W = 2; // burst counter width
    // ****************************************
    // timing
    // ****************************************
    localparam int CORE_PERIOD_NS = 40; // core clock period
    localparam int K_HALF_CYC = 4; // core cycles per link clock phase
    localparam logic [2:0] K_HALF_LAST = 3'(K_HALF_CYC - 1); // divider end
    localparam int DOFF_LOW_NS = 5; // least dll-disable low time
    localparam int DOFF_LOW_CYC = (DOFF_LOW_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int K_STATIC_NS = 30; // link clock static time to dll reset
    localparam int K_STATIC_CYC = (K_STATIC_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam logic [2:0] K_STATIC_LIM = 3'(K_HALF_CYC + K_STATIC_CYC); // edge-free limit
    localparam int DLL_LOCK_KCYC = 2048; // link cycles to relock
    localparam logic [11:0] LOCK_LAST = 12'(DLL_LOCK_KCYC - 1);
    localparam logic [11:0] DOFF_LAST = 12'(DOFF_LOW_CYC - 1);
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000; // data after reset
    localparam logic [LANE_N-1:0] MASK_RST = 2'h3; // all lanes masked
endpackage : b4sp_pkg

// ---- src/b4sp_link_if.sv ----
// link wires between the memory controller and the sram end
`timescale 1ns/100ps
interface b4sp_link_if;
    import b4sp_pkg::*;
    logic k; // link clock, made by the controller
    logic dll_off_n; // dll disable, low resets the dll
    logic rd_sel_n; // read select
    logic wr_sel_n; // write select
    logic [ADDR_W-1:0] addr; // burst address
    logic [LANE_N-1:0] lane_write_mask_n; // per-beat lane masks
    logic [DATA_W-1:0] din; // write data beats
    logic [DATA_W-1:0] q; // read data driven by the sram end
    logic q_oe; // read data output enable
    wire [DATA_W-1:0] q_bus; // resolved read data wire
    logic echo_strobe_pos; // echo clock
    logic echo_strobe_neg; // echo clock complement
    logic read_valid_flag; // read beat valid
    // wire follows the enable; a released wire reads as zero
    assign q_bus = q_oe ? q : '0;
    modport dev (input k, dll_off_n, rd_sel_n, wr_sel_n, addr, lane_write_mask_n, din,
                 output q, q_oe, echo_strobe_pos, echo_strobe_neg, read_valid_flag);
    modport ctl (output k, dll_off_n, rd_sel_n, wr_sel_n, addr, lane_write_mask_n, din,
                 input q_bus, echo_strobe_pos, echo_strobe_neg, read_valid_flag);
endinterface : b4sp_link_if

// ---- src/b4sp_sram_end.sv ----
// sram end of the burst-of-four link: array, burst counters, forwarding, dll
// Behaviour
// - read returns four beats from burst counter
// - write takes four beats, one per location
// - each beat's lane masks guard that beat
// - read of pending write returns its beats
// - outputs disabled on the first link rising edge with no read beat to send
// - controller waits 2048 link cycles for lock
// - dll-disable low at least 5 ns resets
// - link clock static 30 ns resets dll; here only after K_STATIC_LIM = 5 core cycles (200 ns) with no edge
// - controls: read, write select, lane masks
`timescale 1ns/100ps
module b4sp_sram_end (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    b4sp_link_if.dev link,
    output logic dll_locked_o
);
    import b4sp_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int IN_W = 4 + ADDR_W + LANE_N + DATA_W; // sampled pin count
    logic [IN_W-1:0] pin_s1_q; // first stage, read by second only
    logic [IN_W-1:0] pin_s2_q; // settled pins
    logic k_s3_q; // previous link clock level
    logic k_s; // synced link clock
    logic doff_n_s; // synced dll disable
    logic rd_n_s; // synced read select
    logic wr_n_s; // synced write select
    logic [ADDR_W-1:0] addr_s; // synced address
    logic [LANE_N-1:0] mask_n_s; // synced lane masks
    logic [DATA_W-1:0] din_s; // synced write data
    logic k_rise; // link clock rising edge seen
    logic k_edge; // any link clock edge seen

    assign {k_s, doff_n_s, rd_n_s, wr_n_s, addr_s, mask_n_s, din_s} = pin_s2_q;
    assign k_rise = k_s & ~k_s3_q;
    assign k_edge = k_s ^ k_s3_q;

    // two flops on every pin, plus edge history of the clock
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            k_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= {link.k, link.dll_off_n, link.rd_sel_n, link.wr_sel_n, link.addr,
                         link.lane_write_mask_n, link.din};
            pin_s2_q <= pin_s1_q;
            k_s3_q <= k_s;
        end
    end

    // ****************************************
    // dll lock tracking
    // ****************************************
    logic [2:0] idle_q, idle_d; // core cycles since last clock edge
    logic [11:0] lock_q, lock_d; // link cycles since dll reset
    logic locked_q, locked_d; // dll locked
    logic dll_rst; // dll reset request

    // count rising edges after reset; disable pin or a stopped clock restarts it
    always_comb begin
        idle_d = idle_q;
        if (k_edge) begin
            idle_d = 3'h0;
        end else if (idle_q != K_STATIC_LIM) begin
            idle_d = idle_q + 3'h1;
        end
        dll_rst = ~doff_n_s | (idle_q == K_STATIC_LIM);
        lock_d = lock_q;
        locked_d = locked_q;
        if (dll_rst) begin
            lock_d = 12'h000;
            locked_d = 1'b0;
        end else if (k_rise && !locked_q) begin
            lock_d = lock_q + 12'h001;
            locked_d = (lock_q == LOCK_LAST);
        end
    end

    // dll state registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idle_q <= 3'h0;
            lock_q <= 12'h000;
            locked_q <= 1'b0;
        end else begin
            idle_q <= idle_d;
            lock_q <= lock_d;
            locked_q <= locked_d;
        end
    end

    // ****************************************
    // array, pending write and read burst
    // ****************************************
    logic [DATA_W-1:0] mem_q [WORD_N]; // storage array
    logic [DATA_W-1:0] mem_d [WORD_N];
    logic [DATA_W-1:0] pend_q [BEAT_N]; // late-write buffer
    logic [DATA_W-1:0] pend_d [BEAT_N];
    logic [LANE_N-1:0] pmask_q [BEAT_N]; // masks of the buffered beats
    logic [LANE_N-1:0] pmask_d [BEAT_N];
    logic [DATA_W-1:0] eff_w [BEAT_N]; // buffer including this edge's beat
    logic [LANE_N-1:0] eff_m [BEAT_N];
    logic [ADDR_W-1:0] paddr_q, paddr_d; // address of the buffered write
    logic pvalid_q, pvalid_d; // buffer holds an uncommitted write
    logic wact_q, wact_d; // write beats still arriving
    logic [IDX_W-1:0] widx_q, widx_d; // write burst counter
    logic ract_q, ract_d; // read beats still to send
    logic [IDX_W-1:0] ridx_q, ridx_d; // read burst counter
    logic [ADDR_W-1:0] raddr_q, raddr_d; // captured read address
    logic [DATA_W-1:0] dout_q, dout_d; // read data output
    logic oe_q, oe_d; // read data drive enable
    logic vld_q, vld_d; // read valid output
    logic echo_q, echo_d; // echo strobe
    logic echo_n_q, echo_n_d; // echo strobe complement
    logic [DATA_W-1:0] rword; // word chosen for the current read beat

    // replace the unmasked lanes of a word
    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [LANE_N-1:0] mask_n);
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int l = 0; l < LANE_N; l++) begin
            if (!mask_n[l]) begin
                res[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction : lane_merge

    // all burst work happens on a link clock rising edge
    always_comb begin
        mem_d = mem_q;
        pend_d = pend_q;
        pmask_d = pmask_q;
        eff_w = pend_q;
        eff_m = pmask_q;
        paddr_d = paddr_q;
        pvalid_d = pvalid_q;
        wact_d = wact_q;
        widx_d = widx_q;
        ract_d = ract_q;
        ridx_d = ridx_q;
        raddr_d = raddr_q;
        dout_d = dout_q;
        oe_d = oe_q;
        vld_d = vld_q;
        echo_d = echo_q;
        echo_n_d = echo_n_q;
        rword = mem_q[{raddr_q, ridx_q}];
        // the beat arriving now joins the buffer
        if (wact_q) begin
            eff_w[widx_q] = din_s;
            eff_m[widx_q] = mask_n_s;
        end
        // a buffered write to the read address overrides the array
        if (pvalid_q && paddr_q == raddr_q) begin
            rword = lane_merge(rword, pend_q[ridx_q], pmask_q[ridx_q]);
        end
        if (k_rise) begin
            if (ract_q) begin
                // send one beat with its strobes
                dout_d = rword;
                oe_d = 1'b1;
                vld_d = 1'b1;
                echo_d = ~echo_q;
                echo_n_d = echo_q;
                ridx_d = ridx_q + 2'h1;
                if (ridx_q == 2'h3) begin
                    ract_d = 1'b0;
                end
            end else begin
                // nothing to send: release the bus
                oe_d = 1'b0;
                vld_d = 1'b0;
            end
            if (wact_q) begin
                // store the beat in its own slot
                pend_d = eff_w;
                pmask_d = eff_m;
                widx_d = widx_q + 2'h1;
                if (widx_q == 2'h3) begin
                    wact_d = 1'b0;
                end
            end
            if (!wr_n_s) begin
                // new write: commit the previous buffer first
                if (pvalid_q) begin
                    for (int b = 0; b < BEAT_N; b++) begin
                        mem_d[{paddr_q, 2'(b)}] = lane_merge(mem_q[{paddr_q, 2'(b)}],
                                                             eff_w[b], eff_m[b]);
                    end
                end
                paddr_d = addr_s;
                pvalid_d = 1'b1;
                wact_d = 1'b1;
                widx_d = 2'h0;
            end else if (!rd_n_s) begin
                // new read burst starts at beat zero
                raddr_d = addr_s;
                ract_d = 1'b1;
                ridx_d = 2'h0;
            end
        end
    end

    // array and burst registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int w = 0; w < WORD_N; w++) begin
                mem_q[w] <= DATA_RST;
            end
            for (int b = 0; b < BEAT_N; b++) begin
                pend_q[b] <= DATA_RST;
                pmask_q[b] <= MASK_RST;
            end
            paddr_q <= '0;
            pvalid_q <= 1'b0;
            wact_q <= 1'b0;
            widx_q <= 2'h0;
            ract_q <= 1'b0;
            ridx_q <= 2'h0;
            raddr_q <= '0;
            dout_q <= DATA_RST;
            oe_q <= 1'b0;
            vld_q <= 1'b0;
            echo_q <= 1'b0;
            echo_n_q <= 1'b1;
        end else begin
            mem_q <= mem_d;
            pend_q <= pend_d;
            pmask_q <= pmask_d;
            paddr_q <= paddr_d;
            pvalid_q <= pvalid_d;
            wact_q <= wact_d;
            widx_q <= widx_d;
            ract_q <= ract_d;
            ridx_q <= ridx_d;
            raddr_q <= raddr_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            vld_q <= vld_d;
            echo_q <= echo_d;
            echo_n_q <= echo_n_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign link.q = dout_q;
    assign link.q_oe = oe_q;
    assign link.read_valid_flag = vld_q;
    assign link.echo_strobe_pos = echo_q;
    assign link.echo_strobe_neg = echo_n_q;
    assign dll_locked_o = locked_q;
endmodule : b4sp_sram_end

// ---- testbench/b4sp_link_chk.sv ----
// link checker: clock shape, command width, echo strobes and read drive
`timescale 1ns/100ps
module b4sp_link_chk (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic k,
    input wire logic rd_sel_n,
    input wire logic wr_sel_n,
    input wire logic [b4sp_pkg::DATA_W-1:0] q,
    input wire logic q_oe,
    input wire logic echo_strobe_pos,
    input wire logic echo_strobe_neg,
    input wire logic read_valid_flag
);
    import b4sp_pkg::*;
    logic echo_q, echo_d; // echo level one cycle ago
    logic [2:0] beats_q, beats_d; // echo flips seen in this burst
    // ****************************************
    // beat counter
    // ****************************************
    always_comb begin
        echo_d = echo_strobe_pos;
        beats_d = q_oe ? beats_q + 3'(echo_strobe_pos != echo_q) : 3'h0;
    end
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            echo_q <= 1'b0;
            beats_q <= 3'h0;
        end else begin
            echo_q <= echo_d;
            beats_q <= beats_d;
        end
    end
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence k_half_s(v); (k == v) [*4]; endsequence
    sequence held_link_s(s); !s [*8] ##1 s; endsequence
    k_shape_a: assert property ($rose(k) |-> k_half_s(1) ##1 k_half_s(0) ##1 k)
        else $error("link clock shape wrong");
    wr_hold_a: assert property ($fell(wr_sel_n) |-> held_link_s(wr_sel_n))
        else $error("write select width wrong");
    rd_hold_a: assert property ($fell(rd_sel_n) |-> held_link_s(rd_sel_n))
        else $error("read select width wrong");
    sel_excl_a: assert property (rd_sel_n || wr_sel_n)
        else $error("read and write selected together");
    echo_pair_a: assert property (echo_strobe_neg == !echo_strobe_pos)
        else $error("echo pair not complementary");
    valid_oe_a: assert property (read_valid_flag == q_oe)
        else $error("valid flag apart from drive");
    echo_flip_a: assert property ($rose(q_oe) |-> $changed(echo_strobe_pos))
        else $error("first beat without echo edge");
    beat_hold_a: assert property (q_oe && echo_strobe_pos == echo_q |-> $stable(q))
        else $error("read data moved inside a beat");
    burst_beats_a: assert property ($fell(q_oe) |-> beats_q == 3'h4)
        else $error("burst not four beats");
    oe_window_a: assert property ($rose(q_oe) |-> ##[30:34] $fell(q_oe))
        else $error("drive not released after burst");
endmodule : b4sp_link_chk

// ---- testbench/burst4_sram_port_behaviour_tb_top.sv ----
// top bench: controller and sram ends joined by one link
`timescale 1ns/100ps
module burst4_sram_port_behaviour_tb_top;
    import b4sp_pkg::*;
    logic core_clk_i, resetn_i, req_valid_i, req_write_i, dll_reset_i, req_ready_o;
    logic link_ready_o, rd_valid_o, dll_locked_o;
    logic [ADDR_W-1:0] req_addr_i;
    logic [BEAT_N*DATA_W-1:0] req_wdata_i, rd_data_o, d;
    logic [BEAT_N*LANE_N-1:0] req_mask_n_i;
    logic [DATA_W-1:0] mem [WORD_N]; // expected array contents
    int seed, fail_count, checked;
    b4sp_link_if lnk ();
    b4sp_sram_end u_b4sp_sram_end (.core_clk_i, .resetn_i, .link(lnk), .dll_locked_o);
    b4sp_ctl_end u_b4sp_ctl_end (.core_clk_i, .resetn_i, .link(lnk), .req_valid_i,
        .req_write_i, .req_addr_i, .req_wdata_i, .req_mask_n_i, .dll_reset_i,
        .req_ready_o, .link_ready_o, .rd_data_o, .rd_valid_o);
    b4sp_link_chk u_chk (.core_clk_i, .resetn_i, .k(lnk.k), .rd_sel_n(lnk.rd_sel_n),
        .wr_sel_n(lnk.wr_sel_n), .q(lnk.q), .q_oe(lnk.q_oe),
        .echo_strobe_pos(lnk.echo_strobe_pos), .echo_strobe_neg(lnk.echo_strobe_neg),
        .read_valid_flag(lnk.read_valid_flag));
    // compare one value and count it
    task automatic chk(input logic [BEAT_N*DATA_W-1:0] seen, input logic [BEAT_N*DATA_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // expected burst from the array model
    function automatic logic [BEAT_N*DATA_W-1:0] burst(input logic [ADDR_W-1:0] a);
        for (int b = 0; b < BEAT_N; b++) burst[b*DATA_W +: DATA_W] = mem[{a, 2'(b)}];
    endfunction : burst
    // one request; reads are compared, writes update the model per lane
    task automatic req(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [BEAT_N*DATA_W-1:0] wd, input logic [7:0] m);
        logic [BEAT_N*DATA_W-1:0] exp;
        @(posedge core_clk_i);
        #1 {req_write_i, req_addr_i, req_wdata_i, req_mask_n_i, req_valid_i} = {w, a, wd, m, 1'b1};
        exp = burst(a);
        do @(posedge core_clk_i); while (req_ready_o !== 1'b1);
        #1 req_valid_i = 1'b0;
        if (w) begin
            for (int i = 0; i < 8; i++) if (!m[i]) mem[{a, 2'(i/2)}][i%2*9 +: 9] = wd[i*9 +: 9];
        end else begin
            do begin @(posedge core_clk_i); #1; end while (rd_valid_o !== 1'b1);
            chk(rd_data_o, exp);
        end
    endtask : req
    // wait for the lock interval to finish
    task automatic lock_wait;
        for (int n = 0; n < 20000 && !(link_ready_o && dll_locked_o); n++)
            @(posedge core_clk_i);
        chk(link_ready_o, 1);
        chk(dll_locked_o, 1);
        $display("test lock done");
    endtask : lock_wait
    // print counts and verdict, then stop
    task automatic results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    // hang guard
    initial begin
        #(40 * 60000);
        fail_count++;
        results();
    end
    initial begin
        {resetn_i, req_valid_i, req_write_i, dll_reset_i, req_addr_i, req_wdata_i} = '0;
        req_mask_n_i = '1;
        seed = 32'h8826BA24;
        foreach (mem[i]) mem[i] = '0;
        repeat (8) @(posedge core_clk_i);
        #1 resetn_i = 1'b1;
        lock_wait();
        // late write read back at once, then a partial overwrite
        d = 72'({$random(seed), $random(seed), $random(seed)});
        req(1, 4'h5, d, 8'h00);
        req(0, 4'h5, '0, 8'hFF);
        req(1, 4'h5, ~d, 8'hA5);
        req(0, 4'h5, '0, 8'hFF);
        req(0, 4'hF, '0, 8'hFF);
        for (int i = 0; i < 30; i++) begin
            d = 72'({$random(seed), $random(seed), $random(seed)});
            req(1'($random(seed)), 4'($random(seed)), d, 8'($random(seed)));
        end
        for (int a = 0; a < 16; a++) req(0, 4'(a), '0, 8'hFF);
        $display("test traffic done");
        repeat (80) @(posedge core_clk_i);
        #1 chk(lnk.q_oe, 0);
        chk(lnk.echo_strobe_neg, !lnk.echo_strobe_pos);
        dll_reset_i = 1'b1;
        @(posedge core_clk_i);
        #1 dll_reset_i = 1'b0;
        repeat (6) @(posedge core_clk_i);
        chk(link_ready_o, 0);
        chk(dll_locked_o, 0);
        lock_wait();
        results();
    end
endmodule : burst4_sram_port_behaviour_tb_top
